// File: rtl/oct_element.sv
/*
   One phase overcurrent time element with an Avalon-MM register slave.
   Assumes measurements come from relay logic on clock_in, so no
   synchronisers are needed on them.
*/
`timescale 1ns/10ps

// What this block does
// [RULE_01] Current above pickup starts trip timing.
// [RULE_02] Definite curve trips after fixed delay.
// [RULE_03] Definite curve resets at once below pickup.
// [RULE_04] Other curves derive delay from selected curve.
// [RULE_05] Three reset modes for non-definite curves.
// [RULE_06] Instantaneous reset clears accumulator within two cycles.
// [RULE_07] Definite reset waits the reset delay setting.
// [RULE_08] Inverse reset delay follows the selected curve.
// [RULE_09] Time multiplier scales delay, curve-dependent range.
// [RULE_10] Non-thermal delay never below minimum trip delay.
// [RULE_11] Cap is min of 20x pickup, 40x nominal.
// [RULE_12] Minimum delay is curve delay at cap.
// [RULE_13] Measure fundamental, true RMS or negative sequence.
// [RULE_14] Monitor neutral or mains side transformers.
// [RULE_15] Directional only with mains side selected.
// [RULE_16] Direction judged against max torque angle.
// [RULE_17] Phase polarised by opposite line voltage.
// [RULE_18] No reference voltage: trip non-directional or block.
// [RULE_19] Restraint lowers pickup as voltage drops.
// [RULE_20] Restraint voltage phase-phase or phase-ground.
// [RULE_21] Host sets delays of 30 ms with inrush blocking.
// [RULE_22] Accumulate per tick and compare with delay.
module oct_element
   import oct_pkg::*;
#(
   parameter int PHASE = 0,
   parameter int TICK_CYCLES = OCT_TICK_CYCLES
) (
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic [5:0] avs_address_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire oct_meas_t neutral_side_transformer_in,
   input wire oct_meas_t mains_side_transformer_in,
   input wire oct_volt_t volt_in,
   output logic pickup_out,
   output logic trip_out,
   output logic forward_out
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (PHASE < 0 || PHASE > 2) begin : g_bad_phase
      $error("PHASE must be 0, 1 or 2");
   end
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   localparam int TW = $clog2(TICK_CYCLES);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // Curve numerators, in hundredths, shaping each inverse characteristic.
   function automatic logic [13:0] curve_gain(input logic [3:0] c);
      case (c)
         4'h1: curve_gain = 14'h000e;
         4'h2: curve_gain = 14'h0546;
         4'h3: curve_gain = 14'h1f40;
         4'h4: curve_gain = 14'h2ee0;
         4'h5: curve_gain = 14'h0005;
         4'h6: curve_gain = 14'h07a9;
         4'h7: curve_gain = 14'h0b04;
         4'h8, 4'h9, 4'ha, 4'hb: curve_gain = 14'h01f4;
         default: curve_gain = 14'h0064;
      endcase
   endfunction : curve_gain

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [15:0] set_pickup_reg;
   logic [15:0] tdelay_reg;
   logic [15:0] tmult_reg;
   logic [15:0] rdelay_reg;
   logic [15:0] mta_reg;
   logic [15:0] nominal_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;

   wire logic req = avs_read_in | avs_write_in;
   wire logic wr_go = avs_write_in & ack_reg;
   wire logic [3:0] be = avs_byteenable_in;
   wire logic [31:0] wd = avs_writedata_in;

   wire logic enable = ctrl_reg[OCT_EN_BIT];
   wire logic [3:0] curve_raw = ctrl_reg[OCT_CURVE_LSB +: 4];
   wire logic [1:0] rst_mode = ctrl_reg[OCT_RMODE_LSB +: 2];
   wire logic [1:0] method = ctrl_reg[OCT_METHOD_LSB +: 2];
   wire logic mains_side_transformer = ctrl_reg[OCT_CTSIDE_BIT];
   wire logic [1:0] dir_mode = ctrl_reg[OCT_DMODE_LSB +: 2];
   wire logic loss_trip = ctrl_reg[OCT_LOSSTRIP_BIT];
   wire logic vr_en = ctrl_reg[OCT_VREN_BIT];
   wire logic vmode_pg = ctrl_reg[OCT_VMODE_BIT];

   // Undefined curve codes fall back to definite time rather than stall.
   wire logic [3:0] curve = (curve_raw > OCT_CURVE_LAST) ? OCT_CURVE_DEFINITE_TIME_CURVE : curve_raw;
   wire logic is_definite_time_curve = (curve == OCT_CURVE_DEFINITE_TIME_CURVE);
   wire logic is_therm = (curve >= OCT_CURVE_THERM_FIRST);

   // The slave answers one cycle after a request with waitrequest low.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   assign avs_waitrequest_out = req & ~ack_reg;
   assign avs_readdata_out = rdata_reg;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctrl_reg <= OCT_CTRL_RST;
         set_pickup_reg <= OCT_PICKUP_RST;
         tdelay_reg <= OCT_TDELAY_RST;
         tmult_reg <= OCT_TMULT_RST;
         rdelay_reg <= OCT_RDELAY_RST;
         mta_reg <= OCT_MTA_RST;
         nominal_reg <= OCT_NOMINAL_RST;
      end else if (wr_go) begin
         case (avs_address_in)
            OCT_CTRL_OFS: ctrl_reg <= merge16(ctrl_reg, wd, be);
            OCT_PICKUP_OFS: set_pickup_reg <= merge16(set_pickup_reg, wd, be);
            OCT_TDELAY_OFS: tdelay_reg <= merge16(tdelay_reg, wd, be);
            OCT_TMULT_OFS: tmult_reg <= merge16(tmult_reg, wd, be);
            OCT_RDELAY_OFS: rdelay_reg <= merge16(rdelay_reg, wd, be);
            OCT_MTA_OFS: mta_reg <= merge16(mta_reg, wd, be);
            OCT_NOMINAL_OFS: nominal_reg <= merge16(nominal_reg, wd, be);
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Measurement selection and restraint
   // ----------------------------------------------------------------
   wire oct_meas_t meas = mains_side_transformer ? mains_side_transformer_in : neutral_side_transformer_in; // RULE_14
   wire logic [15:0] i_meas = (method == OCT_METH_FUND) ? meas.fund :
      (method == OCT_METH_RMS) ? meas.rms : meas.neg_seq; // RULE_13

   wire logic [15:0] v_restr = vmode_pg ? volt_in.pg_mag : volt_in.pp_mag; // RULE_20
   wire logic [8:0] vr_ratio = (v_restr < {7'h00, OCT_VR_FLOOR}) ? OCT_VR_FLOOR :
      (v_restr > {7'h00, OCT_VR_UNITY}) ? OCT_VR_UNITY : v_restr[8:0];
   wire logic [24:0] pickup_prod = set_pickup_reg * vr_ratio;
   // The floor stops the pickup collapsing to zero on a dead bus.
   wire logic [15:0] pickup_eff = vr_en ? pickup_prod[23:8] : set_pickup_reg; // RULE_19

   wire logic [21:0] cap_pick = 22'(pickup_eff * 22'(OCT_CAP_PICKUP_MULT));
   wire logic [21:0] cap_nom = 22'(nominal_reg * 22'(OCT_CAP_NOMINAL_MULT));
   wire logic [21:0] current_cap = (cap_pick < cap_nom) ? cap_pick : cap_nom; // RULE_11
   // Capping the current before the curve makes the cap's delay the minimum.
   wire logic [21:0] i_capped = (!is_therm && {6'h00, i_meas} > current_cap) ?
      current_cap : {6'h00, i_meas}; // RULE_10 RULE_12

   wire logic above = (i_meas > pickup_eff);

   // ----------------------------------------------------------------
   // Direction
   // ----------------------------------------------------------------
   wire logic [7:0] pol_ang = (PHASE == 0) ? volt_in.line_voltage_two_three :
      (PHASE == 1) ? volt_in.line_voltage_three_one : volt_in.line_voltage_one_two; // RULE_17
   wire logic [7:0] ang_diff = meas.angle - pol_ang - mta_reg[7:0]; // RULE_16
   // Within a quarter turn of the torque angle counts as forward.
   wire logic fwd = (ang_diff[7] == ang_diff[6]);
   wire logic v_ok = volt_in.measured_ok | volt_in.memory_ok;
   wire logic directional = mains_side_transformer && (dir_mode != OCT_DIR_NONE); // RULE_15
   wire logic dir_ok = !directional ? 1'b1 : !v_ok ? loss_trip : // RULE_18
      ((dir_mode == OCT_DIR_FWD) ? fwd : !fwd);

   wire logic run = enable & above & dir_ok; // RULE_01

   // ----------------------------------------------------------------
   // Evaluation tick
   // ----------------------------------------------------------------
   logic [TW-1:0] tick_cnt_reg;
   wire logic tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
   wire logic [TW-1:0] tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Time accumulation and trip decision
   // ----------------------------------------------------------------
   wire logic [15:0] tm_lo = is_therm ? OCT_TM_MIN_TH : OCT_TM_MIN_INV;
   wire logic [15:0] tm_hi = is_therm ? OCT_TM_MAX_TH : OCT_TM_MAX_INV;
   wire logic [15:0] tmult = (tmult_reg < tm_lo) ? tm_lo : (tmult_reg > tm_hi) ? tm_hi : tmult_reg; // RULE_09
   wire logic [31:0] target = is_definite_time_curve ? {16'h0000, tdelay_reg} :
      32'(tmult * curve_gain(curve)); // RULE_04

   // Trip time is target divided by the weight, so weight rises with current.
   wire logic [21:0] excess = i_capped - {6'h00, pickup_eff};
   wire logic [31:0] up_w = is_definite_time_curve ? 32'h0000_0001 : {10'h000, excess}; // RULE_22
   wire logic [15:0] under = pickup_eff - i_meas;
   wire logic [15:0] dn_raw = is_therm ? pickup_eff : under; // RULE_08
   wire logic [31:0] dn_w = {16'h0000, (dn_raw == 16'h0000) ? 16'h0001 : dn_raw};

   logic [31:0] acc_reg;
   logic [15:0] rcnt_reg;
   logic trip_reg;
   logic pick_reg;
   logic fwd_reg;

   wire logic [32:0] add_full = {1'b0, acc_reg} + {1'b0, up_w};
   wire logic [31:0] acc_up = add_full[32] ? 32'hffff_ffff : add_full[31:0];
   wire logic [31:0] acc_dn = (acc_reg > dn_w) ? acc_reg - dn_w : 32'h0000_0000;
   wire logic rdone = (rcnt_reg >= rdelay_reg);

   wire logic [31:0] acc_fall = (is_definite_time_curve || rst_mode == OCT_RST_INST) ? 32'h0000_0000 : // RULE_03 RULE_06
      (rst_mode == OCT_RST_DEFINITE) ? (rdone ? 32'h0000_0000 : acc_reg) : // RULE_07
      (tick ? acc_dn : acc_reg); // RULE_05 RULE_08
   wire logic [31:0] acc_next = run ? (tick ? acc_up : acc_reg) : acc_fall; // RULE_22
   wire logic [15:0] rcnt_next = run ? 16'h0000 :
      ((tick && !rdone) ? rcnt_reg + 16'h0001 : rcnt_reg);
   wire logic trip_next = run && (acc_reg >= target); // RULE_02

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         acc_reg <= '0;
         rcnt_reg <= '0;
         trip_reg <= 1'b0;
         pick_reg <= 1'b0;
         fwd_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         rcnt_reg <= rcnt_next;
         trip_reg <= trip_next;
         pick_reg <= run;
         fwd_reg <= fwd;
      end
   end

   assign pickup_out = pick_reg;
   assign trip_out = trip_reg;
   assign forward_out = fwd_reg;

   // ----------------------------------------------------------------
   // Register read path
   // ----------------------------------------------------------------
   wire logic [31:0] status_word = {28'h0000000, dir_ok, fwd_reg, trip_reg, pick_reg};
   wire logic [31:0] rd_mux = (avs_address_in == OCT_CTRL_OFS) ? {16'h0000, ctrl_reg} :
      (avs_address_in == OCT_PICKUP_OFS) ? {16'h0000, set_pickup_reg} :
      (avs_address_in == OCT_TDELAY_OFS) ? {16'h0000, tdelay_reg} :
      (avs_address_in == OCT_TMULT_OFS) ? {16'h0000, tmult_reg} :
      (avs_address_in == OCT_RDELAY_OFS) ? {16'h0000, rdelay_reg} :
      (avs_address_in == OCT_MTA_OFS) ? {16'h0000, mta_reg} :
      (avs_address_in == OCT_NOMINAL_OFS) ? {16'h0000, nominal_reg} :
      (avs_address_in == OCT_STATUS_OFS) ? status_word :
      (avs_address_in == OCT_ACCUM_OFS) ? acc_reg : 32'h0000_0000;

   // Read data is captured in the wait cycle and stands on the answer cycle.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rdata_reg <= '0;
      end else if (avs_read_in && !ack_reg) begin
         rdata_reg <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);

   property p_start_timing;
      (run && tick && acc_reg < 32'h7fff_ffff) |=> (acc_reg > $past(acc_reg));
   endproperty
   a_start_timing: assert property (p_start_timing) else $error("timing did not advance"); // RULE_01

   property p_definite_time_curve_trip;
      (is_definite_time_curve && run && acc_reg >= {16'h0000, tdelay_reg}) ##1 run |-> trip_out;
   endproperty
   a_definite_time_curve_trip: assert property (p_definite_time_curve_trip) else $error("definite trip missing"); // RULE_02

   property p_definite_time_curve_reset;
      (is_definite_time_curve && !run) |=> (acc_reg == 32'h0000_0000) && !trip_out;
   endproperty
   a_definite_time_curve_reset: assert property (p_definite_time_curve_reset) else $error("definite reset late"); // RULE_03

   property p_inst_reset;
      (!is_definite_time_curve && rst_mode == OCT_RST_INST && !run) |=> (acc_reg == 32'h0000_0000);
   endproperty
   a_inst_reset: assert property (p_inst_reset) else $error("instant reset late"); // RULE_06

   property p_def_reset_hold;
      (!is_definite_time_curve && rst_mode == OCT_RST_DEFINITE && !run && !rdone) |=> acc_reg == $past(acc_reg);
   endproperty
   a_def_reset_hold: assert property (p_def_reset_hold) else $error("reset before delay"); // RULE_07

   property p_min_delay;
      (!is_therm && !is_definite_time_curve && above) |-> ({10'h000, excess} + {6'h00, pickup_eff} <= current_cap);
   endproperty
   a_min_delay: assert property (p_min_delay) else $error("current not capped"); // RULE_10

   property p_cap;
      current_cap <= cap_pick && current_cap <= cap_nom;
   endproperty
   a_cap: assert property (p_cap) else $error("cap not the lesser"); // RULE_11

   property p_neutral_nondir;
      !mains_side_transformer |-> dir_ok;
   endproperty
   a_neutral_nondir: assert property (p_neutral_nondir) else $error("neutral side went directional"); // RULE_15

   property p_loss_block;
      (mains_side_transformer && dir_mode != OCT_DIR_NONE && !v_ok && !loss_trip) |=> !pickup_out;
   endproperty
   a_loss_block: assert property (p_loss_block) else $error("no block on lost voltage"); // RULE_18

   property p_restraint;
      vr_en |-> pickup_eff <= set_pickup_reg;
   endproperty
   a_restraint: assert property (p_restraint) else $error("restraint raised pickup"); // RULE_19

   property p_inv_reset_dn;
      (!is_definite_time_curve && rst_mode[1] && !run && tick && acc_reg != 32'h0000_0000) |=> acc_reg < $past(acc_reg);
   endproperty
   a_inv_reset_dn: assert property (p_inv_reset_dn) else $error("inverse reset stalled"); // RULE_08

   property p_trip_needs_pickup;
      trip_out |-> pickup_out;
   endproperty
   a_trip_needs_pickup: assert property (p_trip_needs_pickup) else $error("trip without pickup"); // RULE_02

endmodule : oct_element

// File: rtl/oct_pkg.sv
/*
   Shared constants and carrier types for the overcurrent time element.
   Assumes one 50 MHz clock and measured quantities delivered on that clock.
*/
package oct_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] OCT_CTRL_OFS = 6'h00;
   localparam logic [5:0] OCT_PICKUP_OFS = 6'h04;
   localparam logic [5:0] OCT_TDELAY_OFS = 6'h08;
   localparam logic [5:0] OCT_TMULT_OFS = 6'h0c;
   localparam logic [5:0] OCT_RDELAY_OFS = 6'h10;
   localparam logic [5:0] OCT_MTA_OFS = 6'h14;
   localparam logic [5:0] OCT_NOMINAL_OFS = 6'h18;
   localparam logic [5:0] OCT_STATUS_OFS = 6'h1c;
   localparam logic [5:0] OCT_ACCUM_OFS = 6'h20;

   // ----------------------------------------------------------------
   // Control field positions and reset values
   // ----------------------------------------------------------------
   localparam int OCT_EN_BIT = 0;
   localparam int OCT_CURVE_LSB = 1;
   localparam int OCT_RMODE_LSB = 5;
   localparam int OCT_METHOD_LSB = 7;
   localparam int OCT_CTSIDE_BIT = 9;
   localparam int OCT_DMODE_LSB = 10;
   localparam int OCT_LOSSTRIP_BIT = 12;
   localparam int OCT_VREN_BIT = 13;
   localparam int OCT_VMODE_BIT = 14;
   localparam logic [15:0] OCT_CTRL_RST = 16'h0000;
   localparam logic [15:0] OCT_PICKUP_RST = 16'h0100;
   localparam logic [15:0] OCT_TDELAY_RST = 16'h0064;
   localparam logic [15:0] OCT_TMULT_RST = 16'h0064;
   localparam logic [15:0] OCT_RDELAY_RST = 16'h0000;
   localparam logic [15:0] OCT_MTA_RST = 16'h0000;
   localparam logic [15:0] OCT_NOMINAL_RST = 16'h0100;

   // ----------------------------------------------------------------
   // Curve, reset mode, measuring method and direction codes
   // ----------------------------------------------------------------
   localparam logic [3:0] OCT_CURVE_DEFINITE_TIME_CURVE = 4'h0;
   localparam logic [3:0] OCT_CURVE_THERM_FIRST = 4'h8;
   localparam logic [3:0] OCT_CURVE_LAST = 4'hb;
   localparam logic [1:0] OCT_RST_INST = 2'h0;
   localparam logic [1:0] OCT_RST_DEFINITE = 2'h1;
   localparam logic [1:0] OCT_METH_FUND = 2'h0;
   localparam logic [1:0] OCT_METH_RMS = 2'h1;
   localparam logic [1:0] OCT_DIR_NONE = 2'h0;
   localparam logic [1:0] OCT_DIR_FWD = 2'h1;

   // ----------------------------------------------------------------
   // Scaling and timing
   // ----------------------------------------------------------------
   localparam int OCT_CAP_PICKUP_MULT = 20;
   localparam int OCT_CAP_NOMINAL_MULT = 40;
   localparam logic [8:0] OCT_VR_UNITY = 9'h100;
   localparam logic [8:0] OCT_VR_FLOOR = 9'h040;
   localparam logic [15:0] OCT_TM_MIN_INV = 16'h0005;
   localparam logic [15:0] OCT_TM_MAX_INV = 16'h07d0;
   localparam logic [15:0] OCT_TM_MIN_TH = 16'h0001;
   localparam logic [15:0] OCT_TM_MAX_TH = 16'h2710;
   localparam int OCT_CLK_MHZ = 50;
   localparam int OCT_TICK_US = 1000;
   localparam int OCT_TICK_CYCLES = OCT_TICK_US * OCT_CLK_MHZ;

   // One measured current set from one transformer side.
   typedef struct packed {
      logic [15:0] fund;
      logic [15:0] rms;
      logic [15:0] neg_seq;
      logic [7:0] angle;
   } oct_meas_t;

   // Polarising and restraint voltages, magnitudes in Q8 per unit.
   typedef struct packed {
      logic [7:0] line_voltage_two_three;
      logic [7:0] line_voltage_three_one;
      logic [7:0] line_voltage_one_two;
      logic [15:0] pp_mag;
      logic [15:0] pg_mag;
      logic measured_ok;
      logic memory_ok;
   } oct_volt_t;

endpackage : oct_pkg

// File: dv/oct_tb.sv
/*
   Self-checking bench for the overcurrent time element: register access over Avalon-MM,
   pickup decisions from a row table, then trip and reset timing cases.
   Assumes the element sits alone on one 50 MHz clock with a shortened tick.
*/
`timescale 1ns/10ps

module tb
   import oct_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals and rows
   // ----------------------------------------------------------------
   localparam int TICK = 4;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] nf;
      logic [15:0] nr;
      logic [15:0] nn;
      logic [15:0] mf;
      logic [7:0] vp;
      logic ok;
      logic [15:0] pp;
      logic [15:0] pg;
      logic pick;
   } oct_tb_row_t;
   logic clock_in = 1'b0;
   logic srst_in = 1'b1;
   logic [5:0] addr = 6'h00;
   logic [3:0] be = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic waitreq;
   oct_meas_t neut = '0;
   oct_meas_t mains = '0;
   oct_volt_t volt = '0;
   logic pickup;
   logic trip;
   logic fwd;
   int n_errors = 0;
   int samples_checked = 0;
   logic [31:0] q;
   logic [31:0] q2;
   int n;
   oct_tb_row_t rows [16];
   logic [5:0] raddr [11];
   logic [31:0] rexp [11];

   oct_element #(.PHASE(0), .TICK_CYCLES(TICK)) u_dut (.clock_in(clock_in), .srst_in(srst_in),
      .avs_address_in(addr), .avs_byteenable_in(be), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .neutral_side_transformer_in(neut), .mains_side_transformer_in(mains), .volt_in(volt),
      .pickup_out(pickup), .trip_out(trip), .forward_out(fwd));

   initial begin
      forever #10 clock_in = ~clock_in;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task end_of_test;
      $display("errors %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk_word

   task chk_bit(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask : chk_bit

   // Waitrequest is judged in the low phase; inputs only move after rising edges, so it is what
   // the next rising edge sees, and sampling there avoids racing the slave's own flops.
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b,
            output logic [31:0] r);
      logic done;
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      be <= b;
      wr <= w;
      rd <= ~w;
      done = 1'b0;
      n = 0;
      r = '0;
      while (!done && n < 20) begin
         @(negedge clock_in);
         n++;
         if (waitreq === 1'b0) begin
            done = 1'b1;
            r = rdata;
         end
         @(posedge clock_in);
      end
      wr <= 1'b0;
      rd <= 1'b0;
      if (!done) begin
         n_errors++;
         $display("FAIL %0t bus wait ran out", $time);
         end_of_test();
      end
   endtask : bus

   task wreg(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'h3, q2);
   endtask : wreg

   task set_in(input logic [15:0] nf, input logic [15:0] mf);
      @(posedge clock_in);
      neut <= '{nf, nf, nf, 8'h00};
      mains <= '{mf, mf, mf, 8'h00};
   endtask : set_in

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      raddr = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h24, 6'h3c};
      // Neutral side is non-directional and zero angles count as forward.
      rexp = '{32'h0, 32'h100, 32'h64, 32'h64, 32'h0, 32'h0, 32'h100, 32'hc, 32'h0, 32'h0, 32'h0};
      rows = '{
         '{16'h0001, 16'h0200, 16'h0200, 16'h0200, 16'h0000, 8'h00, 1'b1, 16'h100, 16'h100, 1'b1},
         '{16'h0001, 16'h0080, 16'h0200, 16'h0200, 16'h0000, 8'h00, 1'b1, 16'h100, 16'h100, 1'b0},
         '{16'h0081, 16'h0080, 16'h0200, 16'h0080, 16'h0000, 8'h00, 1'b1, 16'h100, 16'h100, 1'b1},
         '{16'h0101, 16'h0080, 16'h0080, 16'h0200, 16'h0000, 8'h00, 1'b1, 16'h100, 16'h100, 1'b1},
         '{16'h0000, 16'h0200, 16'h0200, 16'h0200, 16'h0000, 8'h00, 1'b1, 16'h100, 16'h100, 1'b0},
         '{16'h0201, 16'h0200, 16'h0200, 16'h0200, 16'h0080, 8'h00, 1'b1, 16'h100, 16'h100, 1'b0},
         '{16'h0201, 16'h0080, 16'h0080, 16'h0080, 16'h0200, 8'h00, 1'b1, 16'h100, 16'h100, 1'b1},
         '{16'h0401, 16'h0200, 16'h0200, 16'h0200, 16'h0000, 8'h80, 1'b1, 16'h100, 16'h100, 1'b1},
         '{16'h0601, 16'h0000, 16'h0000, 16'h0000, 16'h0200, 8'h80, 1'b1, 16'h100, 16'h100, 1'b0},
         '{16'h0601, 16'h0000, 16'h0000, 16'h0000, 16'h0200, 8'h00, 1'b1, 16'h100, 16'h100, 1'b1},
         '{16'h0a01, 16'h0000, 16'h0000, 16'h0000, 16'h0200, 8'h80, 1'b1, 16'h100, 16'h100, 1'b1},
         '{16'h0601, 16'h0000, 16'h0000, 16'h0000, 16'h0200, 8'h00, 1'b0, 16'h100, 16'h100, 1'b0},
         '{16'h1601, 16'h0000, 16'h0000, 16'h0000, 16'h0200, 8'h80, 1'b0, 16'h100, 16'h100, 1'b1},
         '{16'h0001, 16'h00c0, 16'h00c0, 16'h00c0, 16'h0000, 8'h00, 1'b1, 16'h080, 16'h080, 1'b0},
         '{16'h2001, 16'h00c0, 16'h00c0, 16'h00c0, 16'h0000, 8'h00, 1'b1, 16'h080, 16'h100, 1'b1},
         '{16'h6001, 16'h00c0, 16'h00c0, 16'h00c0, 16'h0000, 8'h00, 1'b1, 16'h080, 16'h100, 1'b0}};
      repeat (4) @(posedge clock_in);
      srst_in <= 1'b0;
      bus(1'b1, 6'h1c, 32'hffff, 4'hf, q);
      bus(1'b1, 6'h24, 32'hffff, 4'hf, q);
      for (int i = 0; i < 11; i++) begin
         bus(1'b0, raddr[i], 32'h0, 4'hf, q);
         chk_word(q, rexp[i], "register reset value");
      end
      bus(1'b1, 6'h04, 32'hffff_ff55, 4'h1, q);
      bus(1'b0, 6'h04, 32'h0, 4'hf, q);
      chk_word(q, 32'h0000_0155, "byte lane write");
      wreg(6'h04, 32'h100);
      // Non-selected polarising angles are inverted; for 8'h00 and 8'h80 this gives the same forward answer as the selected one.
      foreach (rows[i]) begin
         wreg(6'h00, {16'h0, rows[i].ctrl});
         @(posedge clock_in);
         neut <= '{rows[i].nf, rows[i].nr, rows[i].nn, 8'h00};
         mains <= '{rows[i].mf, rows[i].mf, rows[i].mf, 8'h00};
         volt <= '{rows[i].vp, ~rows[i].vp, ~rows[i].vp, rows[i].pp, rows[i].pg, rows[i].ok, rows[i].ok};
         repeat (3) @(posedge clock_in);
         #1 chk_bit(pickup, rows[i].pick, "pickup row");
         chk_bit(fwd, ~rows[i].vp[7], "forward row");
      end
      set_in(16'h0000, 16'h0000);
      volt <= '{8'h00, 8'h80, 8'h80, 16'h100, 16'h100, 1'b1, 1'b1};
      wreg(6'h14, 32'h80);
      repeat (2) @(posedge clock_in);
      #1 chk_bit(fwd, 1'b0, "torque angle turns direction");
      wreg(6'h14, 32'h0);
      // Fixed delay curve: three ticks to trip, tick phase unknown by one tick.
      // No inrush blocking is used here, so the short delay is allowed.
      wreg(6'h08, 32'h3);
      wreg(6'h00, 32'h1);
      set_in(16'h0200, 16'h0000);
      n = 0;
      while (trip !== 1'b1 && n < 100) begin
         @(posedge clock_in) #1;
         n++;
      end
      chk_bit(n >= 2 * TICK && n <= 3 * TICK + 3, 1'b1, "fixed delay trip time");
      set_in(16'h0080, 16'h0000);
      repeat (2) @(posedge clock_in);
      #1 chk_bit(trip, 1'b0, "trip cleared");
      bus(1'b0, 6'h20, 32'h0, 4'hf, q);
      chk_word(q, 32'h0, "accumulator cleared");
      // Inverse curve, instantaneous then definite then inverse reset.
      wreg(6'h00, 32'h3);
      set_in(16'h0200, 16'h0000);
      repeat (6 * TICK) @(posedge clock_in);
      bus(1'b0, 6'h20, 32'h0, 4'hf, q);
      chk_bit(q != 32'h0, 1'b1, "inverse accumulates");
      set_in(16'h0080, 16'h0000);
      repeat (2) @(posedge clock_in);
      bus(1'b0, 6'h20, 32'h0, 4'hf, q);
      chk_word(q, 32'h0, "instant reset");
      wreg(6'h10, 32'h3);
      wreg(6'h00, 32'h23);
      set_in(16'h0200, 16'h0000);
      repeat (6 * TICK) @(posedge clock_in);
      set_in(16'h0080, 16'h0000);
      bus(1'b0, 6'h20, 32'h0, 4'hf, q);
      chk_bit(q != 32'h0, 1'b1, "definite reset holds");
      repeat (4 * TICK + 4) @(posedge clock_in);
      bus(1'b0, 6'h20, 32'h0, 4'hf, q);
      chk_word(q, 32'h0, "definite reset done");
      wreg(6'h00, 32'h43);
      set_in(16'h0200, 16'h0000);
      repeat (8 * TICK) @(posedge clock_in);
      #1 chk_bit(trip, 1'b1, "inverse curve trips");
      set_in(16'h00ff, 16'h0000);
      bus(1'b0, 6'h20, 32'h0, 4'hf, q);
      repeat (2 * TICK) @(posedge clock_in);
      bus(1'b0, 6'h20, 32'h0, 4'hf, q2);
      chk_bit(q2 < q && q2 != 32'h0, 1'b1, "inverse reset winds down");
      // A second reset in mid-run drops the outputs and the settings.
      wreg(6'h00, 32'h1);
      set_in(16'h0200, 16'h0000);
      repeat (4) @(posedge clock_in);
      srst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      #1 chk_bit(pickup, 1'b0, "pickup in reset");
      chk_bit(trip, 1'b0, "trip in reset");
      @(posedge clock_in);
      srst_in <= 1'b0;
      bus(1'b0, 6'h00, 32'h0, 4'hf, q);
      chk_word(q, 32'h0, "control after reset");
      end_of_test();
   end
endmodule : tb
